/* hw/asc_pkg.sv */
// shared constants and carrier types for the converter sequencer
package asc_pkg;
    localparam int unsigned NUM_CH = 5;
    localparam int unsigned RES_W  = 10;
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_DELAY  = 8'h04;
    localparam logic [7:0] OFF_FLAGS  = 8'h08;
    localparam logic [7:0] OFF_ONESEL = 8'h0c;
    localparam logic [7:0] OFF_PERSEL = 8'h10;
    localparam logic [7:0] OFF_RES0   = 8'h14;
    localparam logic [7:0] OFF_RES4   = 8'h24;
    localparam int unsigned CTL_ON      = 0;
    localparam int unsigned CTL_ONESHOT = 1;
    localparam int unsigned CTL_PERIOD  = 2;
    localparam int unsigned CTL_PDONE   = 6;
    localparam int unsigned CTL_ODONE   = 7;
    localparam int unsigned DLY_START_LO = 0;
    localparam int unsigned DLY_REP_LO   = 16;
    localparam int unsigned DLY_W        = 16;
    localparam int unsigned TICK_US  = 40;
    localparam int unsigned CLK_MHZ  = 250;
    localparam int unsigned TICK_CYC = TICK_US * CLK_MHZ;
    localparam logic [31:0] RST_VAL = 32'h0000_0000;

    typedef enum logic [2:0] {
        ASC_IDLE  = 3'b000,
        ASC_WAIT  = 3'b001,
        ASC_PICK  = 3'b010,
        ASC_CONV  = 3'b011,
        ASC_DONE  = 3'b100
    } asc_state_t;

    // request toward the converter core
    typedef struct packed {
        logic       start;
        logic [2:0] chan;
        logic       core_rst;
    } asc_req_t;
endpackage

/* hw/asc_seq.sv */
// five-channel converter sequencer with apb register file
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module asc_seq #(
    parameter int unsigned TICK_CYCLES = asc_pkg::TICK_CYC
) (
    input  wire logic                      CLOCK,     // 250 MHz clock
    input  wire logic                      RESETN,    // main rail reset, low
    input  wire logic                      CLK_EN,    // freezes all state low
    input  wire logic                      PSEL,      // apb select
    input  wire logic                      PENABLE,   // apb access phase
    input  wire logic                      PWRITE,    // apb direction
    input  wire logic [7:0]                PADDR,     // apb byte address
    input  wire logic [31:0]               PWDATA,    // apb write data
    output logic      [31:0]               PRDATA,    // apb read data
    output logic                           PREADY,    // apb ready
    output logic                           PSLVERR,   // apb error
    output asc_pkg::asc_req_t              CORE_REQ,  // request to core
    input  wire logic                      CORE_DONE, // core finished, async
    input  wire logic [asc_pkg::RES_W-1:0] CORE_DATA  // core result
);
    localparam int unsigned NCH = asc_pkg::NUM_CH;
    localparam int unsigned DW  = asc_pkg::DLY_W;

    // the prescaler is sixteen bits wide and channel numbers three bits
    if (TICK_CYCLES < 2 || TICK_CYCLES >= (1 << DW))
        $error("TICK_CYCLES out of range");
    if (NCH > 8)
        $error("NUM_CH exceeds channel index width");

    function automatic logic [2:0] first_set(input logic [NCH-1:0] m);
        logic [2:0] r;
        r = 3'h0;
        for (int i = NCH - 1; i >= 0; i--)
        begin
            if (m[i])
                r = 3'(i);
        end
        return r;
    endfunction

    // control and configuration registers
    logic                 on_r;
    logic                 one_trig_r;
    logic                 per_trig_r;
    logic                 odone_r;
    logic                 pdone_r;
    logic [1:0]           ctl_spare_r;
    logic [31:0]          delay_r;
    logic [NCH-1:0]       flags_r;
    logic [NCH-1:0]       onesel_r;
    logic [NCH-1:0]       persel_r;
    logic [asc_pkg::RES_W-1:0] res_r [NCH];

    // sequencer state
    asc_pkg::asc_state_t  st_r;
    logic                 kind_per_r;
    logic [NCH-1:0]       left_r;
    logic [2:0]           cur_r;
    logic [DW-1:0]        dly_cnt_r;
    logic [15:0]          tick_cnt_r;
    logic                 tick_r;
    logic                 per_started_r;
    logic                 on_d_r;

    // done synchroniser: meta, then two agreeing stages
    logic                 dn_s0_r;
    logic                 dn_s1_r;
    logic                 dn_s2_r;
    logic                 dn_lvl_r;
    logic                 dn_lvl_d_r;
    logic [asc_pkg::RES_W-1:0] data_r;

    wire logic wr_acc = PSEL && PENABLE && PWRITE;
    wire logic [31:0] w = PWDATA;
    wire logic wr_ctl   = wr_acc && PADDR == asc_pkg::OFF_CTRL;
    wire logic wr_dly   = wr_acc && PADDR == asc_pkg::OFF_DELAY;
    wire logic wr_flags = wr_acc && PADDR == asc_pkg::OFF_FLAGS;
    wire logic wr_osel  = wr_acc && PADDR == asc_pkg::OFF_ONESEL;
    wire logic wr_psel  = wr_acc && PADDR == asc_pkg::OFF_PERSEL;
    wire logic conv_end = dn_lvl_r && !dn_lvl_d_r && st_r == asc_pkg::ASC_CONV;
    wire logic pass_beg = st_r == asc_pkg::ASC_PICK && !per_started_r;
    wire logic pass_end = st_r == asc_pkg::ASC_DONE;

    // three-stage sampling of the asynchronous done line
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            dn_s0_r    <= 1'b0;
            dn_s1_r    <= 1'b0;
            dn_s2_r    <= 1'b0;
            dn_lvl_r   <= 1'b0;
            dn_lvl_d_r <= 1'b0;
        end
        else if (CLK_EN)
        begin
            dn_s0_r    <= CORE_DONE;
            dn_s1_r    <= dn_s0_r;
            dn_s2_r    <= dn_s1_r;
            if (dn_s1_r == dn_s2_r)
                dn_lvl_r <= dn_s2_r;
            dn_lvl_d_r <= dn_lvl_r;
        end
    end

    // data is held by the core while done is high, so capture late is safe
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
            data_r <= '0;
        else if (CLK_EN && dn_s2_r)
            data_r <= CORE_DATA;
    end

    // 40 us tick prescaler, restarted whenever a delay is loaded
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b0;
        end
        else if (CLK_EN)
        begin
            tick_r <= 1'b0;
            if (st_r != asc_pkg::ASC_WAIT)
                tick_cnt_r <= '0;
            else if (tick_cnt_r == 16'(TICK_CYCLES - 1))
            begin
                tick_cnt_r <= '0;
                tick_r     <= 1'b1;
            end
            else
                tick_cnt_r <= tick_cnt_r + 16'h0001;
        end
    end

    // control register
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            on_r        <= 1'b0;
            one_trig_r  <= 1'b0;
            per_trig_r  <= 1'b0;
            ctl_spare_r <= 2'h0;
            on_d_r      <= 1'b0;
        end
        else if (CLK_EN)
        begin
            on_d_r <= on_r;
            if (wr_ctl)
            begin
                on_r        <= w[asc_pkg::CTL_ON];
                per_trig_r  <= w[asc_pkg::CTL_PERIOD];
                ctl_spare_r <= w[4:3];
            end
            if (wr_ctl && w[asc_pkg::CTL_ONESHOT])
                one_trig_r <= 1'b1;
            else if (st_r == asc_pkg::ASC_IDLE && one_trig_r && on_r)
                one_trig_r <= 1'b0;
        end
    end

    // pass-done flags: a hardware set wins over a same-cycle clear
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            odone_r <= 1'b0;
            pdone_r <= 1'b0;
        end
        else if (CLK_EN)
        begin
            if (pass_end && !kind_per_r)
                odone_r <= 1'b1;
            else if (pass_beg && !kind_per_r)
                odone_r <= 1'b0;
            else if (wr_ctl && w[asc_pkg::CTL_ODONE])
                odone_r <= 1'b0;
            if (pass_end && kind_per_r)
                pdone_r <= 1'b1;
            else if (pass_beg && kind_per_r)
                pdone_r <= 1'b0;
            else if (wr_ctl && w[asc_pkg::CTL_PDONE])
                pdone_r <= 1'b0;
        end
    end

    // configuration registers
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            delay_r  <= asc_pkg::RST_VAL;
            onesel_r <= '0;
            persel_r <= '0;
        end
        else if (CLK_EN)
        begin
            if (wr_dly)
                delay_r <= w;
            if (wr_osel)
                onesel_r <= w[NCH-1:0];
            if (wr_psel)
                persel_r <= w[NCH-1:0];
        end
    end

    // per-channel done flags and results
    generate
        for (genvar g = 0; g < NCH; g++)
        begin : g_ch
            always_ff @(posedge CLOCK or negedge RESETN)
            begin
                if (!RESETN)
                begin
                    flags_r[g] <= 1'b0;
                    res_r[g]   <= '0;
                end
                else if (CLK_EN)
                begin
                    if (conv_end && cur_r == 3'(g))
                    begin
                        flags_r[g] <= 1'b1;
                        res_r[g]   <= data_r;
                    end
                    else if (wr_flags && w[g])
                        flags_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // sequencer
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            st_r          <= asc_pkg::ASC_IDLE;
            kind_per_r    <= 1'b0;
            left_r        <= '0;
            cur_r         <= 3'h0;
            dly_cnt_r     <= '0;
            per_started_r <= 1'b0;
        end
        else if (CLK_EN)
        begin
            case (st_r)
                asc_pkg::ASC_IDLE:
                begin
                    per_started_r <= 1'b0;
                    if (!on_r)
                        st_r <= asc_pkg::ASC_IDLE;
                    else if (one_trig_r)
                    begin
                        kind_per_r <= 1'b0;
                        left_r     <= onesel_r;
                        st_r       <= asc_pkg::ASC_PICK;
                    end
                    else if (per_trig_r)
                    begin
                        kind_per_r <= 1'b1;
                        dly_cnt_r  <= delay_r[asc_pkg::DLY_START_LO +: DW];
                        st_r       <= asc_pkg::ASC_WAIT;
                    end
                end
                asc_pkg::ASC_WAIT:
                begin
                    if (!per_trig_r || !on_r)
                        st_r <= asc_pkg::ASC_IDLE;
                    else if (dly_cnt_r == '0)
                    begin
                        left_r <= persel_r;
                        st_r   <= asc_pkg::ASC_PICK;
                    end
                    else if (tick_r)
                        dly_cnt_r <= dly_cnt_r - 16'h0001;
                end
                asc_pkg::ASC_PICK:
                begin
                    per_started_r <= 1'b1;
                    if (left_r == '0)
                        st_r <= asc_pkg::ASC_DONE;
                    else
                    begin
                        cur_r <= first_set(left_r);
                        st_r  <= asc_pkg::ASC_CONV;
                    end
                end
                asc_pkg::ASC_CONV:
                begin
                    if (conv_end)
                    begin
                        left_r[cur_r] <= 1'b0;
                        st_r          <= asc_pkg::ASC_PICK;
                    end
                end
                asc_pkg::ASC_DONE:
                begin
                    per_started_r <= 1'b0;
                    if (kind_per_r && per_trig_r && on_r)
                    begin
                        dly_cnt_r <= delay_r[asc_pkg::DLY_REP_LO +: DW];
                        st_r      <= asc_pkg::ASC_WAIT;
                    end
                    else
                        st_r <= asc_pkg::ASC_IDLE;
                end
                default:
                    st_r <= asc_pkg::ASC_IDLE;
            endcase
        end
    end

    // converter core request
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
            CORE_REQ <= '0;
        else if (CLK_EN)
        begin
            CORE_REQ.start    <= st_r == asc_pkg::ASC_CONV && !dn_lvl_r;
            CORE_REQ.chan     <= cur_r;
            CORE_REQ.core_rst <= on_r && !on_d_r;
        end
    end

    // apb read path, zero wait states
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            PRDATA  <= '0;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end
        else if (CLK_EN)
        begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= 1'b0;
            PRDATA  <= '0;
            if (PSEL && !PENABLE && !PWRITE)
            begin
                if (PADDR == asc_pkg::OFF_CTRL)
                    PRDATA <= {24'h0, odone_r, pdone_r, 1'b0,
                               ctl_spare_r, per_trig_r,
                               one_trig_r, on_r};
                else if (PADDR == asc_pkg::OFF_DELAY)
                    PRDATA <= delay_r;
                else if (PADDR == asc_pkg::OFF_FLAGS)
                    PRDATA <= {27'h0, flags_r};
                else if (PADDR == asc_pkg::OFF_ONESEL)
                    PRDATA <= {27'h0, onesel_r};
                else if (PADDR == asc_pkg::OFF_PERSEL)
                    PRDATA <= {27'h0, persel_r};
                else if (PADDR >= asc_pkg::OFF_RES0 &&
                         PADDR <= asc_pkg::OFF_RES4 && PADDR[1:0] == 2'h0)
                    PRDATA <= {22'h0, res_r[3'((PADDR - asc_pkg::OFF_RES0)
                               >> 2)]};
                else
                    PSLVERR <= 1'b1;
            end
            else if (PSEL && !PENABLE && PWRITE &&
                     PADDR != asc_pkg::OFF_CTRL &&
                     PADDR != asc_pkg::OFF_DELAY &&
                     PADDR != asc_pkg::OFF_FLAGS &&
                     PADDR != asc_pkg::OFF_ONESEL &&
                     PADDR != asc_pkg::OFF_PERSEL)
                PSLVERR <= 1'b1;
        end
    end

    property p_flag_set;
        @(posedge CLOCK) disable iff (!RESETN)
        CLK_EN && conv_end |=> flags_r[$past(cur_r)];
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("channel flag not set");

    property p_zero_keeps;
        @(posedge CLOCK) disable iff (!RESETN)
        CLK_EN && !wr_flags |=> ($past(flags_r) & ~flags_r) == '0;
    endproperty
    a_zero_keeps: assert property (p_zero_keeps)
        else $error("flag dropped without write");

    property p_odone;
        @(posedge CLOCK) disable iff (!RESETN)
        CLK_EN && pass_end && !kind_per_r |=> odone_r;
    endproperty
    a_odone: assert property (p_odone)
        else $error("one-shot done missing");

    property p_pdone;
        @(posedge CLOCK) disable iff (!RESETN)
        CLK_EN && pass_end && kind_per_r |=> pdone_r;
    endproperty
    a_pdone: assert property (p_pdone)
        else $error("periodic done missing");

    property p_upper_zero;
        @(posedge CLOCK) disable iff (!RESETN)
        PREADY && PADDR >= asc_pkg::OFF_RES0 |-> PRDATA[31:10] == 22'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("result upper bits not zero");

    property p_trig_clear;
        @(posedge CLOCK) disable iff (!RESETN)
        CLK_EN && st_r == asc_pkg::ASC_IDLE && one_trig_r && on_r && !wr_ctl
        |=> !one_trig_r;
    endproperty
    a_trig_clear: assert property (p_trig_clear)
        else $error("one-shot trigger stuck");

    property p_zero_delay;
        @(posedge CLOCK) disable iff (!RESETN)
        CLK_EN && st_r == asc_pkg::ASC_WAIT && dly_cnt_r == '0 && per_trig_r
        && on_r |=> st_r == asc_pkg::ASC_PICK;
    endproperty
    a_zero_delay: assert property (p_zero_delay)
        else $error("zero delay waited");

    property p_core_rst;
        @(posedge CLOCK) disable iff (!RESETN)
        CLK_EN && on_r && !on_d_r |=> CORE_REQ.core_rst;
    endproperty
    a_core_rst: assert property (p_core_rst)
        else $error("core reset pulse missing");
endmodule

/* verification/asc_core_model.sv */
// behavioural converter core answering the sequencer's channel requests
`timescale 1ns/1ps
module asc_core_model (
    input  wire logic         CLOCK,  // bench clock
    input  wire logic         RESETN, // reset, low
    input  wire logic         SLOW,   // lengthens each conversion
    input  asc_pkg::asc_req_t REQ,    // request from the sequencer
    output logic              DONE,   // conversion finished
    output logic [9:0]        DATA    // conversion result
);
    int cnt;

    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            cnt  <= 0;
            DONE <= 1'b0;
            DATA <= 10'h155;
        end
        else if (REQ.start && !DONE)
        begin
            cnt <= cnt + 1;
            if (cnt >= (SLOW ? 9 : 2))
            begin
                DONE <= 1'b1;
                DATA <= 10'h2c0 | 10'(REQ.chan);
            end
        end
        else if (!REQ.start && DONE)
        begin
            cnt  <= 0;
            DONE <= 1'b0;
            // result is not held once released, so no stale value can pass
            DATA <= ~DATA;
        end
    end
endmodule

/* verification/test_asc_seq.sv */
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
module test_asc_seq;
    localparam int TK    = 8;
    localparam int LIMIT = 30000;
    logic              clock = 1'b0;
    logic              resetn = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic              slow = 1'b0;
    logic              clk_en = 1'b1;
    logic [7:0]        paddr = 8'h00;
    logic [31:0]       pwdata = 32'h0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    asc_pkg::asc_req_t core_req;
    logic              core_done;
    logic [9:0]        core_data;
    logic              st_q = 1'b0;
    logic [4:0]        seen = 5'h00;
    logic [31:0]       r;
    logic              e;
    int                cyc = 0;
    int                n_rise = 0;
    int                n_rst = 0;
    int                t_rise = 0;
    int                t_fall = 0;
    int                t0;
    int                n0;
    int                i;
    int                n_mismatch = 0;
    int                comparisons = 0;

    always #2 clock = ~clock;

    asc_seq #(.TICK_CYCLES(TK)) asc_seq_inst (
        .CLOCK(clock), .RESETN(resetn), .CLK_EN(clk_en), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .CORE_REQ(core_req), .CORE_DONE(core_done),
        .CORE_DATA(core_data)
    );

    asc_core_model asc_core_model_inst (
        .CLOCK(clock), .RESETN(resetn), .SLOW(slow), .REQ(core_req),
        .DONE(core_done), .DATA(core_data)
    );

    task automatic final_report();
        begin
            if (n_mismatch == 0 && comparisons > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask

    task automatic chk(input string n, input logic [31:0] s,
                       input logic [31:0] x);
        begin
            comparisons++;
            if (s !== x)
            begin
                n_mismatch++;
                $display("MISMATCH %s expected %h seen %h", n, x, s);
            end
        end
    endtask

    // timestamps of request edges let delays be judged at the core side
    always @(posedge clock)
    begin
        cyc  <= cyc + 1;
        st_q <= core_req.start;
        if (core_req.start && !st_q)
        begin
            n_rise <= n_rise + 1;
            t_rise <= cyc;
            seen   <= seen | (5'h01 << core_req.chan);
        end
        if (!core_req.start && st_q)
            t_fall <= cyc;
        if (core_req.core_rst)
            n_rst <= n_rst + 1;
        if (cyc == LIMIT)
        begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd_v,
                       output logic err);
        int k;
        begin
            @(posedge clock);
            psel    <= 1'b1;
            pwrite  <= w;
            paddr   <= a;
            pwdata  <= d;
            @(posedge clock);
            penable <= 1'b1;
            k = 0;
            do
            begin
                @(posedge clock);
                k++;
            end
            while (pready !== 1'b1 && k < 50);
            if (pready !== 1'b1)
                n_mismatch++;
            rd_v = prdata;
            err  = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic        y;
        apb(1'b1, a, d, x, y);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic y;
        apb(1'b0, a, 32'h0, d, y);
    endtask

    task automatic wait_rise(input int n);
        int k;
        begin
            k = 0;
            while (n_rise < n && k < 2000)
            begin
                @(posedge clock);
                k++;
            end
            chk("request", 32'(n_rise >= n), 32'h1);
        end
    endtask

    task automatic poll(input int b);
        logic [31:0] v;
        int          k;
        begin
            k = 0;
            v = 32'h0;
            while (v[b] !== 1'b1 && k < 300)
            begin
                rd(asc_pkg::OFF_CTRL, v);
                k++;
            end
            chk("pass done", {31'h0, v[b]}, 32'h1);
        end
    endtask

    initial
    begin
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        for (i = 0; i < 10; i++)
        begin
            rd(8'(4 * i), r);
            chk("reset value", r, 32'h0);
        end
        apb(1'b0, 8'h28, 32'h0, r, e);
        chk("unmapped", {31'h0, e}, 32'h1);
        // channel 1 stays out of the one-shot mask, so its zero proves this
        apb(1'b1, asc_pkg::OFF_RES0 + 8'h04, 32'h3ff, r, e);
        chk("result write refused", {31'h0, e}, 32'h1);
        wr(asc_pkg::OFF_CTRL, 32'h1);
        repeat (4) @(posedge clock);
        chk("core reset", 32'(n_rst), 32'h1);
        // one-shot pass with long delays programmed, mask kept steady
        wr(asc_pkg::OFF_DELAY, 32'h0005_0005);
        wr(asc_pkg::OFF_ONESEL, 32'h15);
        seen = 5'h00;
        t0 = cyc;
        wr(asc_pkg::OFF_CTRL, 32'h3);
        wait_rise(n_rise + 1);
        chk("oneshot lead", 32'(t_rise - t0 < 12), 32'h1);
        poll(asc_pkg::CTL_ODONE);
        rd(asc_pkg::OFF_CTRL, r);
        chk("oneshot trigger", {31'h0, r[1]}, 32'h0);
        chk("oneshot channels", {27'h0, seen}, 32'h15);
        rd(asc_pkg::OFF_FLAGS, r);
        chk("channel flags", r, 32'h15);
        for (i = 0; i < 5; i++)
        begin
            rd(asc_pkg::OFF_RES0 + 8'(4 * i), r);
            chk("result", r, ((5'h15 >> i) & 5'h1) ?
                {22'h0, 10'h2c0 | 10'(i)} : 32'h0);
        end
        wr(asc_pkg::OFF_FLAGS, 32'h0);
        rd(asc_pkg::OFF_FLAGS, r);
        chk("flags zero write", r, 32'h15);
        wr(asc_pkg::OFF_FLAGS, 32'h1);
        rd(asc_pkg::OFF_FLAGS, r);
        chk("flags one write", r, 32'h14);
        wr(asc_pkg::OFF_CTRL, 32'h99);
        rd(asc_pkg::OFF_CTRL, r);
        chk("oneshot done clear", {31'h0, r[7]}, 32'h0);
        chk("ctrl storage", {30'h0, r[4:3]}, 32'h3);
        // periodic passes: start two ticks, repeat three ticks, slow core
        wr(asc_pkg::OFF_DELAY, 32'h0003_0002);
        wr(asc_pkg::OFF_PERSEL, 32'h0a);
        seen = 5'h00;
        slow = 1'b1;
        n0 = n_rise;
        t0 = cyc;
        wr(asc_pkg::OFF_CTRL, 32'h5);
        wait_rise(n0 + 1);
        chk("start delay", 32'(t_rise - t0 >= TK &&
            t_rise - t0 <= 2 * TK + 16), 32'h1);
        wait_rise(n0 + 2);
        poll(asc_pkg::CTL_PDONE);
        chk("periodic channels", {27'h0, seen}, 32'h0a);
        wait_rise(n0 + 3);
        chk("repeat gap", 32'(t_rise - t_fall >= 2 * TK &&
            t_rise - t_fall <= 3 * TK + 16), 32'h1);
        rd(asc_pkg::OFF_CTRL, r);
        chk("periodic done clear", {31'h0, r[6]}, 32'h0);
        // one channel a pass makes every request a pass boundary
        wr(asc_pkg::OFF_PERSEL, 32'h08);
        wr(asc_pkg::OFF_DELAY, 32'h0);
        n0 = n_rise;
        wait_rise(n0 + 3);
        chk("zero repeat", 32'(t_rise - t_fall <= TK + 4), 32'h1);
        wait_rise(n_rise + 1);
        wr(asc_pkg::OFF_CTRL, 32'h1);
        poll(asc_pkg::CTL_PDONE);
        n0 = n_rise;
        repeat (60) @(posedge clock);
        chk("no further pass", 32'(n_rise), 32'(n0));
        t0 = cyc;
        wr(asc_pkg::OFF_CTRL, 32'h5);
        wait_rise(n0 + 1);
        chk("zero start", 32'(t_rise - t0 <= 12), 32'h1);
        // clock enable low freezes the sequencer in mid conversion
        clk_en <= 1'b0;
        n0 = n_rise;
        repeat (40) @(posedge clock);
        chk("frozen", 32'(n_rise), 32'(n0));
        clk_en <= 1'b1;
        wait_rise(n0 + 1);
        // converter off in mid pass: the pass ends, nothing follows
        wr(asc_pkg::OFF_CTRL, 32'h4);
        poll(asc_pkg::CTL_PDONE);
        n0 = n_rise;
        repeat (60) @(posedge clock);
        chk("no pass when off", 32'(n_rise), 32'(n0));
        final_report();
    end
endmodule
